// file: src/wpl_pkg.sv
// package: register offsets, field positions, reset values and unlock key values
package wpl_pkg;
  // register offsets on the internal register port
  localparam logic [7:0] BOOST_CURRENT_LIMIT_CTRL_OFS     = 8'h32;
  localparam logic [7:0] OTP_CORRECTION_STATUS_OFS        = 8'h33;
  localparam logic [7:0] PIN_DISABLE_UNLOCK_KEY_OFS       = 8'h34;
  localparam logic [7:0] WATCHDOG_PIN_DISABLE_CONTROL_OFS = 8'h35;
  // field positions
  localparam int BOOST_LIMIT_LSB      = 0;
  localparam int DOUBLE_ERR_BIT       = 1;
  localparam int SINGLE_ERR_BIT       = 0;
  localparam int CTRL_LOCK_BIT        = 1;
  localparam int PERMISSION_BIT       = 0;
  // reset values
  localparam logic [5:0] RSVD_RESET     = 6'h00;
  localparam logic       LOCK_RESET     = 1'b1;
  localparam logic [7:0] KEY_READ_VALUE = 8'h00;
  localparam logic [1:0] BOOST_LIMIT_RESET = 2'h0;
  localparam logic       PERM_RESET        = 1'b0;
  localparam logic       FLAG_RESET        = 1'b0;
  localparam logic [7:0] RDATA_RESET       = 8'h00;
  // unlock key sequence
  localparam logic [7:0] UNLOCK_VALUE_0 = 8'h87;
  localparam logic [7:0] UNLOCK_VALUE_1 = 8'h65;
  localparam logic [7:0] UNLOCK_VALUE_2 = 8'h1b;
  // unlock tracking states
  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_GOT_FIRST,
    KEY_GOT_SECOND
  } wpl_key_state_t;
endpackage : wpl_pkg

// file: src/wpl_regs.sv
// register group: boost current limit, otp error flags, watchdog pin-disable lock
`timescale 1ns/1ps
`default_nettype none

// How it works
// - two-bit read/write boost current limit at bits 1..0, codes 1.0/1.4/1.9/2.8 A.
// - current limit and permission bit load their defaults from otp values.
// - read-only double-error flag at bit 1 follows the otp uncorrected error.
// - read-only single-error flag at bit 0 follows the otp corrected error.
// - with master lock zero, writes 0x87, 0x65, 0x1b in three consecutive key writes clear the lock.
// - any other key register write sets the control lock.
// - writing one to the master lock sets the control lock.
// - reading the key register always returns zero.
// - control lock reads at bit 1, resets to one (locked).
// - while control lock is one, permission bit writes are ignored.
// - the off pin disables the watchdog only when permission is one.
// - a one is written to permission only when both locks are zero.
module wpl_regs
  import wpl_pkg::*;
(
  input  wire logic       ref_clk_i,                 // 20 mhz clock
  input  wire logic       rst_n_i,                   // async reset, active low
  input  wire logic       reg_wr_i,                  // register write strobe
  input  wire logic       reg_rd_i,                  // register read strobe
  input  wire logic [7:0] reg_addr_i,                // register offset
  input  wire logic [7:0] reg_wdata_i,               // write data
  output logic      [7:0] reg_rdata_o,               // read data, one cycle after read
  input  wire logic       otp_load_i,                // pulse: load defaults from otp
  input  wire logic [1:0] otp_boost_current_limit_i, // otp default current limit
  input  wire logic       otp_pin_disable_perm_i,    // otp default permission
  input  wire logic       otp_double_error_flag_i,   // otp uncorrected error seen
  input  wire logic       otp_single_error_flag_i,   // otp corrected error seen
  input  wire logic       watchdog_master_lock_i,    // master lock level
  input  wire logic       master_lock_set_i,         // pulse: master lock written one
  input  wire logic       watchdog_off_pin_i,        // external watchdog-disable pin
  output logic      [1:0] boost_current_limit_o,     // current limit select
  output logic            pin_disable_permission_o,  // permission bit
  output logic            pin_disable_control_lock_o,// control lock status
  output logic            watchdog_off_o             // watchdog disabled by pin
);

  logic [1:0]     boost_limit_q;
  logic [5:0]     boost_rsvd_q;
  logic [5:0]     ctrl_rsvd_q;
  logic           perm_q;
  logic           lock_q;
  logic           dbl_err_q;
  logic           sgl_err_q;
  logic           wdog_off_q;
  logic [7:0]     rdata_q;
  wpl_key_state_t key_q;
  logic           key_wr;
  logic           key_done;
  logic           ctrl_wr;
  logic           boost_wr;

  // address match for one register of the group
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction : addr_hit

  // write decode
  assign boost_wr = reg_wr_i && addr_hit(reg_addr_i, BOOST_CURRENT_LIMIT_CTRL_OFS);
  assign key_wr   = reg_wr_i && addr_hit(reg_addr_i, PIN_DISABLE_UNLOCK_KEY_OFS);
  assign ctrl_wr  = reg_wr_i && addr_hit(reg_addr_i, WATCHDOG_PIN_DISABLE_CONTROL_OFS);
  // third key value closes the sequence
  assign key_done = key_wr && !watchdog_master_lock_i && (key_q == KEY_GOT_SECOND)
                    && (reg_wdata_i == UNLOCK_VALUE_2);

  // boost current limit register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      boost_limit_q <= BOOST_LIMIT_RESET;
      boost_rsvd_q  <= RSVD_RESET;
    end else if (otp_load_i) begin
      boost_limit_q <= otp_boost_current_limit_i;
    end else if (boost_wr) begin
      boost_limit_q <= reg_wdata_i[BOOST_LIMIT_LSB +: 2];
      boost_rsvd_q  <= reg_wdata_i[7:2];
    end
  end

  // otp error flags mirror neighbouring ecc logic
  // flags come from neighbours
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dbl_err_q <= FLAG_RESET;
      sgl_err_q <= FLAG_RESET;
    end else begin
      dbl_err_q <= otp_double_error_flag_i;
      sgl_err_q <= otp_single_error_flag_i;
    end
  end

  // unlock key tracking
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      key_q <= KEY_IDLE;
    end else if (watchdog_master_lock_i || master_lock_set_i) begin
      key_q <= KEY_IDLE;
    end else if (key_wr) begin
      case (key_q)
        KEY_IDLE:       key_q <= (reg_wdata_i == UNLOCK_VALUE_0) ? KEY_GOT_FIRST : KEY_IDLE;
        KEY_GOT_FIRST:  key_q <= (reg_wdata_i == UNLOCK_VALUE_1) ? KEY_GOT_SECOND : KEY_IDLE;
        KEY_GOT_SECOND: key_q <= KEY_IDLE;
        default:        key_q <= KEY_IDLE;
      endcase
    end else if (reg_wr_i) begin
      // another write breaks consecutiveness
      key_q <= KEY_IDLE;
    end
  end

  // control lock
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_q <= LOCK_RESET;
    end else if (master_lock_set_i || watchdog_master_lock_i) begin
      lock_q <= 1'b1;
    end else if (key_done) begin
      lock_q <= 1'b0;
    end else if (key_wr) begin
      lock_q <= 1'b1;
    end
  end

  // permission bit and control reserved bits
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      perm_q      <= PERM_RESET;
      ctrl_rsvd_q <= RSVD_RESET;
    end else if (otp_load_i) begin
      perm_q <= otp_pin_disable_perm_i;
    end else if (ctrl_wr) begin
      ctrl_rsvd_q <= reg_wdata_i[7:2];
      if (!lock_q && !watchdog_master_lock_i) begin
        perm_q <= reg_wdata_i[PERMISSION_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wdog_off_q <= 1'b0;
    end else begin
      wdog_off_q <= perm_q && watchdog_off_pin_i;
    end
  end

  // read data register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= RDATA_RESET;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        BOOST_CURRENT_LIMIT_CTRL_OFS:     rdata_q <= {boost_rsvd_q, boost_limit_q};
        OTP_CORRECTION_STATUS_OFS:        rdata_q <= {6'h00, dbl_err_q, sgl_err_q};
        PIN_DISABLE_UNLOCK_KEY_OFS:       rdata_q <= KEY_READ_VALUE;
        WATCHDOG_PIN_DISABLE_CONTROL_OFS: rdata_q <= {ctrl_rsvd_q, lock_q, perm_q};
        default:                          rdata_q <= 8'h00;
      endcase
    end
  end

  // outputs straight from flops
  assign reg_rdata_o                = rdata_q;
  assign boost_current_limit_o      = boost_limit_q;
  assign pin_disable_permission_o   = perm_q;
  assign pin_disable_control_lock_o = lock_q;
  assign watchdog_off_o             = wdog_off_q;

  // full key clears lock next cycle
  a_unlock_opens: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    key_done && !master_lock_set_i |=> !lock_q)
    else $error("lock not cleared after key");

  a_bad_key_locks: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    key_wr && !key_done |=> lock_q)
    else $error("lock not set by key write");

  a_master_locks: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    master_lock_set_i |=> lock_q)
    else $error("lock not set by master lock");

  a_master_holds: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    watchdog_master_lock_i |=> lock_q && key_q == KEY_IDLE)
    else $error("unlock while master locked");

  a_key_reads_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    reg_rd_i && reg_addr_i == PIN_DISABLE_UNLOCK_KEY_OFS |=> reg_rdata_o == 8'h00)
    else $error("key register read not zero");

  a_perm_locked: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    lock_q && !otp_load_i |=> $stable(perm_q))
    else $error("permission changed while locked");

  a_pin_gated: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !perm_q |=> !watchdog_off_o)
    else $error("pin acted without permission");

  a_key_restart: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    key_wr && key_q == KEY_GOT_FIRST && reg_wdata_i != UNLOCK_VALUE_1 |=> key_q == KEY_IDLE)
    else $error("key tracking not restarted");

  a_boost_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    boost_wr && !otp_load_i |=> boost_current_limit_o == $past(reg_wdata_i[1:0]))
    else $error("boost limit not written");

  a_otp_defaults: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    otp_load_i |=> boost_current_limit_o == $past(otp_boost_current_limit_i)
    && pin_disable_permission_o == $past(otp_pin_disable_perm_i))
    else $error("otp defaults not loaded");

  a_double_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    1'b1 |=> dbl_err_q == $past(otp_double_error_flag_i))
    else $error("double error flag wrong");

  a_single_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    1'b1 |=> sgl_err_q == $past(otp_single_error_flag_i))
    else $error("single error flag wrong");

  a_status_upper: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    reg_rd_i && reg_addr_i == OTP_CORRECTION_STATUS_OFS |=> reg_rdata_o[7:2] == 6'h00)
    else $error("status reserved bits set");

  a_key_first: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    key_wr && !watchdog_master_lock_i && !master_lock_set_i && key_q == KEY_IDLE
    && reg_wdata_i == UNLOCK_VALUE_0 |=> key_q == KEY_GOT_FIRST)
    else $error("first key value not taken");

  a_key_second: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    key_wr && !watchdog_master_lock_i && !master_lock_set_i && key_q == KEY_GOT_FIRST
    && reg_wdata_i == UNLOCK_VALUE_1 |=> key_q == KEY_GOT_SECOND)
    else $error("second key value not taken");

  a_other_write_breaks: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    reg_wr_i && !key_wr |=> key_q == KEY_IDLE)
    else $error("key kept across other write");

  a_master_clears_key: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    master_lock_set_i |=> key_q == KEY_IDLE)
    else $error("key kept after master lock write");

  a_lock_readback: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    reg_rd_i && reg_addr_i == WATCHDOG_PIN_DISABLE_CONTROL_OFS
    |=> reg_rdata_o[CTRL_LOCK_BIT] == $past(lock_q))
    else $error("lock status read wrong");

  a_perm_accepts: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ctrl_wr && !otp_load_i && !lock_q && !watchdog_master_lock_i
    |=> pin_disable_permission_o == $past(reg_wdata_i[PERMISSION_BIT]))
    else $error("permission write not taken");

  a_perm_master: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    watchdog_master_lock_i && !otp_load_i |=> $stable(perm_q))
    else $error("permission changed under master lock");

  a_pin_passes: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    perm_q && watchdog_off_pin_i |=> watchdog_off_o)
    else $error("pin ignored with permission");

  a_boost_readback: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    reg_rd_i && reg_addr_i == BOOST_CURRENT_LIMIT_CTRL_OFS
    |=> reg_rdata_o[1:0] == $past(boost_limit_q))
    else $error("boost limit read wrong");

endmodule : wpl_regs

`default_nettype wire

// file: verif/wpl_host.sv
// host model: register strobe port as driven by the i2c front end
`timescale 1ns/1ps
`default_nettype none
module wpl_host (
  input  wire logic       clk_i,   // bench clock
  input  wire logic [7:0] rdata_i, // read data
  output logic            wr_o,    // write strobe
  output logic            rd_o,    // read strobe
  output logic      [7:0] addr_o,  // register offset
  output logic      [7:0] wdata_o  // write data
);
  // idle bus at time zero
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // one write, then scramble the released data lines, address held
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
    #1;
  endtask : wr
  // one read, data taken one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask : rd
endmodule : wpl_host
`default_nettype wire

// file: verif/wpl_regs_bench.sv
// bench: register group against an integer model
`timescale 1ns/1ps
`default_nettype none
module wpl_regs_bench;
  import wpl_pkg::*;
  logic       clk, rst_n, otp_ld, ml, ml_set, pin, oded, osed, operm, wr, rd;
  logic       perm_o, lock_o, off_o;
  logic [1:0] olim, lim_o;
  logic [7:0] addr, wdata, rdata, rv;
  int         fail_count, checks, seed, perm, lock, ks, r32, r35, i;
  logic [7:0] kv [3] = '{UNLOCK_VALUE_0, UNLOCK_VALUE_1, UNLOCK_VALUE_2};

  wpl_host i_wpl_host (.clk_i(clk), .rdata_i(rdata), .wr_o(wr), .rd_o(rd),
    .addr_o(addr), .wdata_o(wdata));
  wpl_regs i_wpl_regs (.ref_clk_i(clk), .rst_n_i(rst_n), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .otp_load_i(otp_ld),
    .otp_boost_current_limit_i(olim), .otp_pin_disable_perm_i(operm),
    .otp_double_error_flag_i(oded), .otp_single_error_flag_i(osed),
    .watchdog_master_lock_i(ml), .master_lock_set_i(ml_set), .watchdog_off_pin_i(pin),
    .boost_current_limit_o(lim_o), .pin_disable_permission_o(perm_o),
    .pin_disable_control_lock_o(lock_o), .watchdog_off_o(off_o));

  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // write through the host and update the model
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    if (a == PIN_DISABLE_UNLOCK_KEY_OFS) begin
      // any key write closes, only the third good value reopens
      lock = 1;
      if (ml == 1'b0 && d == kv[ks]) ks++;
      else ks = 0;
      if (ks == 3) begin
        ks = 0;
        lock = 0;
      end
    end else ks = 0;
    if (a == 8'h32) r32 = d;
    if (a == 8'h35) begin
      r35 = d & 8'hfc;
      if (lock == 0 && ml == 1'b0) perm = d[0];
    end
    i_wpl_host.wr(a, d);
  endtask : wreg
  // read, compare with model, and compare the limit, lock and permission outputs
  task automatic rchk(input logic [7:0] a);
    logic [7:0] e;
    case (a)
      8'h32: e = 8'(r32);
      8'h33: e = {6'h00, oded, osed};
      8'h35: e = 8'(r35 | (lock << 1) | perm);
      default: e = 8'h00;
    endcase
    i_wpl_host.rd(a, rv);
    chk(rv, e);
    chk({6'h00, lim_o}, 8'(r32 & 3));
    chk({6'h00, lock_o, perm_o}, 8'((lock << 1) | perm));
  endtask : rchk
  task automatic keys(input logic [7:0] k1);
    wreg(PIN_DISABLE_UNLOCK_KEY_OFS, kv[0]);
    wreg(PIN_DISABLE_UNLOCK_KEY_OFS, k1);
    wreg(PIN_DISABLE_UNLOCK_KEY_OFS, kv[2]);
  endtask : keys
  // hang guard
  initial begin
    #1ms;
    fail_count++;
    give_verdict();
  end
  // main sequence
  initial begin
    {rst_n, otp_ld, ml, ml_set, pin, oded, osed, operm, olim} = '0;
    {fail_count, checks, perm, ks, r32, r35} = '0;
    lock = 1;
    seed = 76233;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 8'h32; i < 8'h37; i++) rchk(8'(i));
    // every limit code with random reserved bits
    for (i = 0; i < 4; i++) begin
      wreg(8'h32, {6'($random(seed)), 2'(i)});
      rchk(8'h32);
    end
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      {oded, osed} <= 2'(i);
      @(posedge clk);
      rchk(8'h33);
    end
    // locked write ignored, then unlock and write
    wreg(8'h35, 8'h01);
    rchk(8'h35);
    keys(kv[1]);
    rchk(8'h34);
    wreg(8'h35, 8'hf1);
    rchk(8'h35);
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      pin <= i[0];
      @(posedge clk);
      #1;
      chk({7'h00, off_o}, 8'(perm & i));
    end
    // wrong key relocks, broken sequence stays locked
    wreg(PIN_DISABLE_UNLOCK_KEY_OFS, 8'(8'h00));
    wreg(8'h35, 8'h00);
    rchk(8'h35);
    wreg(PIN_DISABLE_UNLOCK_KEY_OFS, kv[0]);
    keys(kv[1] ^ 8'h01);
    rchk(8'h35);
    keys(kv[1]);
    rchk(8'h35);
    // even a first good value relocks an open lock
    wreg(PIN_DISABLE_UNLOCK_KEY_OFS, kv[0]);
    rchk(8'h35);
    // another write between key values breaks the sequence
    wreg(8'h36, 8'h00);
    wreg(PIN_DISABLE_UNLOCK_KEY_OFS, kv[1]);
    wreg(PIN_DISABLE_UNLOCK_KEY_OFS, kv[2]);
    rchk(8'h35);
    // master lock write relocks and blocks the key
    @(posedge clk);
    ml <= 1'b1;
    ml_set <= 1'b1;
    @(posedge clk);
    ml_set <= 1'b0;
    lock = 1;
    ks = 0;
    rchk(8'h35);
    keys(kv[1]);
    wreg(8'h35, 8'h00);
    rchk(8'h35);
    @(posedge clk);
    ml <= 1'b0;
    // defaults loaded from otp, even while locked
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      olim <= 2'($random(seed));
      operm <= i[0];
      otp_ld <= 1'b1;
      @(posedge clk);
      otp_ld <= 1'b0;
      r32 = (r32 & 8'hfc) | olim;
      perm = i;
      rchk(8'h32);
      rchk(8'h35);
      chk({7'h00, off_o}, 8'(perm & pin));
    end
    // mid-run reset brings every register back
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    {perm, ks, r32, r35} = '0;
    lock = 1;
    for (i = 8'h32; i < 8'h36; i++) rchk(8'(i));
    chk({7'h00, off_o}, 8'(perm & pin));
    give_verdict();
  end
endmodule : wpl_regs_bench
`default_nettype wire
